// ---- verilog/oms_cfg.svh ----
// constants of the operating mode supervisor
// assumes a 100 MHz ref_clk and synchronous event inputs from the spi block
// Contract
// RQ1: leave start-up at threshold; host pin selects mode
// RQ2: host or standalone choice latched until reset
// RQ3: host, undervoltage, low battery: start-up fail, supply off
// RQ4: start-up fail: converter follows dimming if battery ok
// RQ5: host normal mode needs timely watchdog triggers
// RQ6: standalone normal mode entered and kept regardless
// RQ7: normal modes: converter follows dimming input
// RQ8: soft request enters software fallback, defaults restored
// RQ9: software fallback: converter follows fallback enable
// RQ10: watchdog, overtemp or stuck input enter fallback
// RQ11: normal undervoltage over 2 ms enters fallback
// RQ12: start-up below fail level over 4 ms
// RQ13: start-up undervoltage over 100 ms, battery ok
// RQ14: hardware fallback restores defaults, keeps soft bit
// RQ15: hardware fallback: converter follows fallback enable
// RQ16: clear status then trigger watchdog returns normal
// RQ17: power-on reset always ends fallback
// RQ18: host overtemp: regulator off, fallback, failsafe set; code ignores overtemp while already in hardware fallback
// RQ19: overtemp recovery by enable toggle or external supply
// RQ20: standalone overtemp: regulator off, stay normal
// RQ21: standalone dither default, low serial input disables
// RQ22: monitor output copies dimming input unless selected
// RQ23: three watchdog timeouts need reset or enable toggle; code also returns on clear then trigger when ext_supply is set
// RQ24: clear soft bit and trigger watchdog leaves it
// RQ25: six coded states, evaluated every clock cycle
`ifndef OMS_CFG_SVH
`define OMS_CFG_SVH
`define OMS_CLK_MHZ 100
`define OMS_UV_NORM_US 2000
`define OMS_FAIL_START_US 4000
`define OMS_UV_START_US 100000
`define OMS_WD_LIMIT 2'h3
`define OMS_MUX_DIM 2'h0
`endif

// ---- verilog/oms_pkg.sv ----
// types of the operating mode supervisor
// assumes nothing beyond the constants header
package oms_pkg;
  typedef enum logic [2:0] {
    OMS_START = 3'h0,
    OMS_START_FAIL = 3'h1,
    OMS_NORM_HOST = 3'h2,
    OMS_NORM_ALONE = 3'h3,
    OMS_SW_FB = 3'h4,
    OMS_HW_FB = 3'h5
  } oms_state_t;
  typedef enum logic [2:0] {
    OMS_C_NONE = 3'h0,
    OMS_C_WD = 3'h1,
    OMS_C_UV = 3'h2,
    OMS_C_STUCK = 3'h3,
    OMS_C_OT = 3'h4,
    OMS_C_START = 3'h5
  } oms_cause_t;
  // pin and comparator levels from outside the clock domain
  typedef struct packed {
    logic host_detect_reset_pin;
    logic fallback_enable_input;
    logic dim_logic_input;
    logic serial_data_input;
    logic enable_input;
    logic supply_above_startup;
    logic supply_above_fail;
    logic battery_above_min;
    logic regulator_overtemp;
  } oms_pins_t;
  // one-cycle events and levels from the spi block
  typedef struct packed {
    logic wd_trigger;
    logic wd_timeout;
    logic status_clear;
    logic serial_input_stuck_event;
    logic soft_fallback_request_bit;
  } oms_spi_t;
  typedef struct packed {
    logic failsafe;
    logic watchdog_failure_flag;
    logic supply_undervoltage_timeout_flag;
    logic serial_input_stuck_flag;
    logic soft_fallback_status_flag;
    logic regulator_overtemp_flag;
    logic startup_timeout_flag;
  } oms_status_t;
endpackage

// ---- verilog/oms_timer.sv ----
// qualifying timer: fires once a condition has held longer than LIMIT
// assumes run is a synchronous level on ref_clk
`timescale 1ns/10ps
`default_nettype none
module oms_timer #(
  parameter int unsigned LIMIT = 4
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic run,
  output logic expired
);
  localparam int W = $clog2(LIMIT + 1);
  typedef struct packed {
    logic [W-1:0] cnt;
  } oms_tmr_t;
  oms_tmr_t s;
  oms_tmr_t next_s;

  // saturate so a long hold keeps the expiry asserted
  always_comb begin
    next_s = s;
    if (!run) begin
      next_s.cnt = '0;
    end else if (s.cnt != W'(LIMIT)) begin
      next_s.cnt = s.cnt + W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // strictly longer than LIMIT cycles of holding
  assign expired = run && (s.cnt == W'(LIMIT));
endmodule
`default_nettype wire

// ---- verilog/oms_supervisor.sv ----
// operating mode supervisor of the led converter controller
// assumes rst_b is the power-on reset and spi events are on ref_clk
`timescale 1ns/10ps
`default_nettype none
`include "oms_cfg.svh"
module oms_supervisor
  import oms_pkg::*;
#(
  parameter int unsigned UV_NORM_CYC = `OMS_UV_NORM_US * `OMS_CLK_MHZ,
  parameter int unsigned FAIL_START_CYC =
    `OMS_FAIL_START_US * `OMS_CLK_MHZ,
  parameter int unsigned UV_START_CYC = `OMS_UV_START_US * `OMS_CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire oms_pins_t pins,
  input wire oms_spi_t spi,
  input wire logic ext_supply,
  input wire logic [1:0] monitor_select,
  output oms_state_t mode,
  output logic host_mode,
  output logic converter_on,
  output logic logic_supply_enable,
  output logic control_defaults_restore,
  output logic dither_enable,
  output logic monitor_mux_output,
  output logic [1:0] monitor_mux_select,
  output oms_status_t status
);
  typedef struct packed {
    oms_pins_t sync1;
    oms_pins_t sync2;
    logic en_prev;
    oms_state_t st;
    oms_cause_t cause;
    logic host;
    logic clear_seen;
    logic [1:0] wd_cnt;
    logic reg_off;
    oms_status_t stat;
    logic conv;
    logic supply_en;
    logic restore;
    logic dither;
    logic mux_out;
    logic [1:0] mux_sel;
  } oms_reg_t;
  oms_reg_t s;
  oms_reg_t next_s;
  oms_pins_t p;
  oms_status_t set_v;
  logic uv_norm_exp;
  logic fail_start_exp;
  logic uv_start_exp;
  logic en_rise;
  logic ot_now;
  logic wd_limit;
  logic spi_ok;
  logic en_ok;
  logic start_fail_go;

  // only the second stage is ever read
  assign p = s.sync2;
  assign en_rise = p.enable_input && !s.en_prev;
  assign ot_now = p.regulator_overtemp;
  assign wd_limit = (s.wd_cnt == `OMS_WD_LIMIT);

  // RQ16 recovery by status clear then trigger
  assign spi_ok = ext_supply || ((s.cause == OMS_C_WD) && !wd_limit) ||
                  (s.cause == OMS_C_UV) || (s.cause == OMS_C_STUCK);
  // RQ23 enable toggle for the hard causes
  assign en_ok = (s.cause == OMS_C_OT) || (s.cause == OMS_C_START) ||
                 ((s.cause == OMS_C_WD) && wd_limit);
  // RQ3 live host pin, start-up only
  assign start_fail_go = p.host_detect_reset_pin &&
                         !p.supply_above_startup && !p.battery_above_min;

  // RQ11 normal-mode undervoltage qualifier
  oms_timer #(.LIMIT(UV_NORM_CYC)) u_uv_norm (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(s.st == OMS_NORM_HOST && !p.supply_above_startup),
    .expired(uv_norm_exp)
  );
  // RQ12 start-up below fail level
  oms_timer #(.LIMIT(FAIL_START_CYC)) u_fail_start (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(s.st == OMS_START && p.host_detect_reset_pin &&
         !p.supply_above_fail),
    .expired(fail_start_exp)
  );
  // RQ13 start-up undervoltage with battery present
  oms_timer #(.LIMIT(UV_START_CYC)) u_uv_start (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(s.st == OMS_START && p.host_detect_reset_pin &&
         !p.supply_above_startup && p.battery_above_min),
    .expired(uv_start_exp)
  );

  // RQ25 one decision per clock cycle
  always_comb begin
    next_s = s;
    set_v = '0;
    next_s.sync1 = pins;
    next_s.sync2 = s.sync1;
    next_s.en_prev = p.enable_input;
    if (spi.status_clear) begin
      next_s.clear_seen = 1'b1;
    end
    unique case (s.st)
      OMS_START: begin
        // RQ18 overtemp with the host pin high leaves start-up
        if (ot_now && p.host_detect_reset_pin) begin
          next_s.st = OMS_HW_FB;
          next_s.cause = OMS_C_OT;
          next_s.reg_off = 1'b1;
          set_v.regulator_overtemp_flag = 1'b1;
        // RQ12 RQ13 start-up timeouts
        end else if (fail_start_exp || uv_start_exp) begin
          next_s.st = OMS_HW_FB;
          next_s.cause = OMS_C_START;
          next_s.reg_off = 1'b1;
          set_v.startup_timeout_flag = 1'b1;
        // RQ1 RQ2 threshold reached, mode latched here only
        end else if (p.supply_above_startup) begin
          next_s.host = p.host_detect_reset_pin;
          next_s.st = p.host_detect_reset_pin ? OMS_NORM_HOST
                                              : OMS_NORM_ALONE;
        // RQ3 start-up fail
        end else if (start_fail_go) begin
          next_s.st = OMS_START_FAIL;
        end
      end
      OMS_START_FAIL: begin
        // left only by power-on reset or overtemp
        if (ot_now) begin
          next_s.st = OMS_HW_FB;
          next_s.cause = OMS_C_OT;
          next_s.reg_off = 1'b1;
          set_v.regulator_overtemp_flag = 1'b1;
        end
      end
      OMS_NORM_HOST: begin
        if (spi.wd_trigger) begin
          next_s.wd_cnt = 2'h0;
        end
        // RQ18 regulator off, failsafe
        if (ot_now) begin
          next_s.st = OMS_HW_FB;
          next_s.cause = OMS_C_OT;
          next_s.reg_off = 1'b1;
          set_v.regulator_overtemp_flag = 1'b1;
        // RQ5 RQ10 missed watchdog
        end else if (spi.wd_timeout) begin
          next_s.st = OMS_HW_FB;
          next_s.cause = OMS_C_WD;
          set_v.watchdog_failure_flag = 1'b1;
          // RQ23 the entering timeout counts, saturating at the limit
          if (!wd_limit) begin
            next_s.wd_cnt = s.wd_cnt + 2'h1;
          end
        // RQ11 long undervoltage
        end else if (uv_norm_exp) begin
          next_s.st = OMS_HW_FB;
          next_s.cause = OMS_C_UV;
          set_v.supply_undervoltage_timeout_flag = 1'b1;
        // RQ10 stuck serial input
        end else if (spi.serial_input_stuck_event) begin
          next_s.st = OMS_HW_FB;
          next_s.cause = OMS_C_STUCK;
          set_v.serial_input_stuck_flag = 1'b1;
        // RQ8 software request
        end else if (spi.soft_fallback_request_bit) begin
          next_s.st = OMS_SW_FB;
        end
      end
      OMS_NORM_ALONE: begin
        // RQ6 RQ20 stays normal, regulator off for good
        if (ot_now) begin
          next_s.reg_off = 1'b1;
          set_v.regulator_overtemp_flag = 1'b1;
        end
      end
      OMS_SW_FB: begin
        if (ot_now) begin
          next_s.st = OMS_HW_FB;
          next_s.cause = OMS_C_OT;
          next_s.reg_off = 1'b1;
          set_v.regulator_overtemp_flag = 1'b1;
        // RQ24 soft bit cleared then watchdog trigger
        end else if (!spi.soft_fallback_request_bit && spi.wd_trigger) begin
          next_s.st = OMS_NORM_HOST;
        end
      end
      OMS_HW_FB: begin
        // RQ23 consecutive timeouts keep counting
        if (spi.wd_timeout && s.cause == OMS_C_WD && !wd_limit) begin
          next_s.wd_cnt = s.wd_cnt + 2'h1;
        end
        // RQ16 RQ19 status read-clear then trigger
        if (s.clear_seen && spi.wd_trigger && spi_ok &&
            p.supply_above_startup) begin
          next_s.st = OMS_NORM_HOST;
          next_s.cause = OMS_C_NONE;
          next_s.reg_off = 1'b0;
        // RQ19 RQ23 enable pin toggled off and on
        end else if (en_rise && en_ok) begin
          next_s.st = OMS_NORM_HOST;
          next_s.cause = OMS_C_NONE;
          next_s.reg_off = 1'b0;
          next_s.wd_cnt = 2'h0;
        end
      end
      default: begin
        next_s.st = OMS_HW_FB;
        next_s.cause = OMS_C_NONE;
      end
    endcase
    // RQ10 every hardware entry marks failsafe
    if (next_s.st == OMS_HW_FB && s.st != OMS_HW_FB) begin
      set_v.failsafe = 1'b1;
      next_s.clear_seen = 1'b0;
    end
    // set wins over the clear in the same cycle
    if (spi.status_clear) begin
      next_s.stat = set_v;
      // RQ19 a status clear drops the overtemp bit only for an externally supplied host
      next_s.stat.regulator_overtemp_flag = set_v.regulator_overtemp_flag ||
        (s.stat.regulator_overtemp_flag && !ext_supply);
    end else begin
      next_s.stat = s.stat | set_v;
    end
    // RQ16 RQ24 a return to normal reports failsafe 0
    if (next_s.st == OMS_NORM_HOST && s.st != OMS_NORM_HOST) begin
      next_s.stat.failsafe = 1'b0;
      next_s.stat.watchdog_failure_flag = 1'b0;
      next_s.stat.supply_undervoltage_timeout_flag = 1'b0;
      next_s.stat.serial_input_stuck_flag = 1'b0;
      // RQ19 a restart after shutdown also drops the overtemp bit
      next_s.stat.regulator_overtemp_flag = 1'b0;
    end
    next_s.stat.soft_fallback_status_flag = (next_s.st == OMS_SW_FB);
    // converter on/off follows the state being entered
    unique case (next_s.st)
      // RQ4 battery gates the dimming input
      OMS_START_FAIL: next_s.conv = p.battery_above_min &&
                                    p.dim_logic_input;
      // RQ7 dimming input in both normal modes
      OMS_NORM_HOST, OMS_NORM_ALONE: next_s.conv = p.dim_logic_input;
      // RQ9 RQ15 fallback enable drives the converter
      OMS_SW_FB, OMS_HW_FB: next_s.conv = p.fallback_enable_input;
      default: next_s.conv = 1'b0;
    endcase
    // RQ3 RQ18 RQ20 supply off in start-up fail or after shutdown
    next_s.supply_en = (next_s.st != OMS_START_FAIL) && !next_s.reg_off;
    // RQ8 RQ14 register block holds defaults, soft bit untouched
    next_s.restore = (next_s.st == OMS_SW_FB) || (next_s.st == OMS_HW_FB);
    // RQ21 low serial input disables dither when standalone
    next_s.dither = (next_s.st != OMS_NORM_ALONE) || p.serial_data_input;
    // RQ22 default selection shows the dimming input
    next_s.mux_sel = next_s.restore ? `OMS_MUX_DIM : monitor_select;
    next_s.mux_out = (next_s.mux_sel == `OMS_MUX_DIM) && p.dim_logic_input;
  end

  // RQ17 power-on reset returns everything to start-up
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign mode = s.st;
  assign host_mode = s.host;
  assign converter_on = s.conv;
  assign logic_supply_enable = s.supply_en;
  assign control_defaults_restore = s.restore;
  assign dither_enable = s.dither;
  assign monitor_mux_output = s.mux_out;
  assign monitor_mux_select = s.mux_sel;
  assign status = s.stat;

  // checks; sequences name the single-cycle recovery condition and the normal state after it
  sequence clear_then_trigger;
    s.st == OMS_HW_FB && s.clear_seen && spi.wd_trigger && spi_ok &&
    p.supply_above_startup;
  endsequence
  sequence back_to_normal;
    s.st == OMS_NORM_HOST && !s.stat.failsafe;
  endsequence

  host_latch_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ2
    (s.st != OMS_START && $past(s.st) != OMS_START) |-> $stable(s.host))
    else $error("host mode changed after start-up");
  startup_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ1
    (s.st == OMS_START && p.supply_above_startup && !ot_now &&
     !fail_start_exp && !uv_start_exp) |=>
    (s.st == (s.host ? OMS_NORM_HOST : OMS_NORM_ALONE)))
    else $error("start-up did not enter normal mode");
  fail_supply_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ3
    s.st == OMS_START_FAIL |-> !logic_supply_enable)
    else $error("supply on in start-up fail");
  norm_dim_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ7
    (s.st == OMS_NORM_HOST || s.st == OMS_NORM_ALONE) |->
    converter_on == $past(p.dim_logic_input))
    else $error("converter not following dimming input");
  fb_enable_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ15
    (s.st == OMS_HW_FB || s.st == OMS_SW_FB) |->
    converter_on == $past(p.fallback_enable_input) && control_defaults_restore)
    else $error("fallback output wrong");
  alone_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ6
    s.st == OMS_NORM_ALONE |=> s.st == OMS_NORM_ALONE)
    else $error("standalone normal mode left");
  wd_entry_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ10
    (s.st == OMS_NORM_HOST && spi.wd_timeout) |=>
    (s.st == OMS_HW_FB && s.stat.failsafe) ##1 s.st == OMS_HW_FB)
    else $error("watchdog timeout not handled");
  uv_entry_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ11
    (s.st == OMS_NORM_HOST && uv_norm_exp && !ot_now && !spi.wd_timeout)
    |=> s.stat.supply_undervoltage_timeout_flag && s.st == OMS_HW_FB)
    else $error("undervoltage timeout missed");
  recover_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ16
    clear_then_trigger |=> back_to_normal)
    else $error("recovery to normal failed");
  ot_alone_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ20
    (s.st == OMS_NORM_ALONE && ot_now) |=> !logic_supply_enable [*2])
    else $error("standalone overtemp kept regulator on");
endmodule
`default_nettype wire

// ---- verif/oms_host_model.sv ----
// host microcontroller seen through the spi block: events and soft request
// assumes the supervisor samples spi on the rising edge of ref_clk
`timescale 1ns/10ps
`default_nettype none
module oms_host_model
  import oms_pkg::*;
(
  input wire logic ref_clk,
  output oms_spi_t spi
);
  // quiet bus until the bench asks for something
  initial spi = '0;
  // one-cycle event on bit k, launched off the falling edge
  task ev(input int k);
    @(negedge ref_clk);
    spi[k] = 1'b1;
    @(negedge ref_clk);
    spi[k] = 1'b0;
  endtask
  // clear then trigger
  // gap lets the host answer promptly or slowly
  task recover(input int gap);
    ev(2);
    repeat (gap) @(negedge ref_clk);
    ev(4);
  endtask
  task soft_set();
    @(negedge ref_clk);
    spi.soft_fallback_request_bit = 1'b1;
  endtask
  // soft bit dropped with trigger
  // both in one cycle, as the exit needs them together
  task soft_exit();
    @(negedge ref_clk);
    spi.soft_fallback_request_bit = 1'b0;
    spi.wd_trigger = 1'b1;
    @(negedge ref_clk);
    spi.wd_trigger = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verif/oms_supervisor_tb.sv ----
// self-checking bench of the operating mode supervisor
// assumes short timer limits; pins need 3 edges, spi events 1 edge
`timescale 1ns/10ps
`default_nettype none
module oms_supervisor_tb;
  import oms_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  oms_pins_t pins = 9'h13E;
  oms_spi_t spi;
  logic ext_supply = 1'b0;
  logic [1:0] msel = 2'h0;
  oms_state_t mode;
  logic host_mode, conv, sup_en, restore, dither, mux_out;
  logic [1:0] mux_sel;
  oms_status_t status;
  int err_count = 0;
  int samples_checked = 0;
  // short limits keep the start-up timeouts within a few hundred cycles
  oms_supervisor #(.UV_NORM_CYC(20), .FAIL_START_CYC(40),
    .UV_START_CYC(100)) u_oms_supervisor (.ref_clk(ref_clk),
    .rst_b(rst_b), .pins(pins), .spi(spi), .ext_supply(ext_supply),
    .monitor_select(msel), .mode(mode), .host_mode(host_mode),
    .converter_on(conv), .logic_supply_enable(sup_en),
    .control_defaults_restore(restore), .dither_enable(dither),
    .monitor_mux_output(mux_out), .monitor_mux_select(mux_sel),
    .status(status));
  oms_host_model u_oms_host_model (.ref_clk(ref_clk), .spi(spi));
  always #5 ref_clk = ~ref_clk;
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task ev(input int k);
    u_oms_host_model.ev(k);
    cyc(1);
  endtask
  task rec(input int gap);
    u_oms_host_model.recover(gap);
    cyc(1);
  endtask
  task chk(input string nm, input logic [7:0] seen,
    input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // power-on reset with the given pin levels already settled
  task rst(input oms_pins_t p);
    pins = p;
    rst_b = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    cyc(5);
  endtask
  task toggle_en();
    pins.enable_input = 1'b0;
    cyc(4);
    pins.enable_input = 1'b1;
    cyc(5);
  endtask
  task t_start();
    rst(9'h13E);
    chk("mode", mode, OMS_NORM_HOST);
    chk("host", host_mode, 1'b1);
    chk("supply", sup_en, 1'b1);
    for (int i = 1; i >= 0; i--) begin
      pins.dim_logic_input = i[0];
      cyc(4);
      chk("conv", conv, i[0]);
      chk("mux", mux_out, i[0]);
    end
    msel = 2'h2;
    cyc(2);
    chk("msel", mux_sel, 2'h2);
    // a non-default selection must not copy the dimming input
    pins.dim_logic_input = 1'b1;
    cyc(4);
    chk("mux", mux_out, 1'b0);
    pins.host_detect_reset_pin = 1'b0;
    cyc(4);
    chk("latch", host_mode, 1'b1);
    chk("mode", mode, OMS_NORM_HOST);
  endtask
  task t_wd();
    pins.fallback_enable_input = 1'b1;
    ev(3);
    chk("mode", mode, OMS_HW_FB);
    chk("fs", status.failsafe, 1'b1);
    chk("wdf", status.watchdog_failure_flag, 1'b1);
    chk("dflt", restore, 1'b1);
    chk("msel", mux_sel, 2'h0);
    chk("conv", conv, 1'b1);
    pins.fallback_enable_input = 1'b0;
    cyc(4);
    chk("conv", conv, 1'b0);
    rec(3);
    chk("mode", mode, OMS_NORM_HOST);
    chk("st", status, 8'h00);
    chk("dflt", restore, 1'b0);
  endtask
  task t_uv();
    // a dip shorter than the limit must be ignored
    pins.supply_above_startup = 1'b0;
    cyc(10);
    pins.supply_above_startup = 1'b1;
    cyc(6);
    chk("mode", mode, OMS_NORM_HOST);
    pins.supply_above_startup = 1'b0;
    cyc(30);
    chk("mode", mode, OMS_HW_FB);
    chk("uvf", status.supply_undervoltage_timeout_flag, 1'b1);
    pins.supply_above_startup = 1'b1;
    cyc(4);
    rec(1);
    chk("mode", mode, OMS_NORM_HOST);
  endtask
  task t_stuck();
    ev(1);
    chk("mode", mode, OMS_HW_FB);
    chk("sif", status.serial_input_stuck_flag, 1'b1);
    // trigger without the status read must not leave
    ev(4);
    chk("mode", mode, OMS_HW_FB);
    rec(5);
    chk("mode", mode, OMS_NORM_HOST);
    chk("sif", status.serial_input_stuck_flag, 1'b0);
  endtask
  task t_soft();
    u_oms_host_model.soft_set();
    cyc(2);
    chk("mode", mode, OMS_SW_FB);
    chk("dflt", restore, 1'b1);
    chk("ssf", status.soft_fallback_status_flag, 1'b1);
    pins.fallback_enable_input = 1'b1;
    cyc(4);
    chk("conv", conv, 1'b1);
    pins.fallback_enable_input = 1'b0;
    cyc(4);
    chk("conv", conv, 1'b0);
    u_oms_host_model.soft_exit();
    cyc(1);
    chk("mode", mode, OMS_NORM_HOST);
    chk("st", status, 8'h00);
  endtask
  task t_ot();
    pins.regulator_overtemp = 1'b1;
    cyc(4);
    chk("mode", mode, OMS_HW_FB);
    chk("supply", sup_en, 1'b0);
    chk("fs", status.failsafe, 1'b1);
    pins.regulator_overtemp = 1'b0;
    cyc(4);
    // host on the internal supply cannot clear this cause
    rec(1);
    chk("mode", mode, OMS_HW_FB);
    chk("otf", status.regulator_overtemp_flag, 1'b1);
    toggle_en();
    chk("mode", mode, OMS_NORM_HOST);
    chk("otf", status.regulator_overtemp_flag, 1'b0);
    chk("supply", sup_en, 1'b1);
  endtask
  task t_three();
    rst(9'h13E);
    for (int i = 0; i < 3; i++) begin
      ev(3);
      if (i < 2) begin
        rec(1);
        chk("mode", mode, OMS_NORM_HOST);
      end
    end
    rec(1);
    chk("mode", mode, OMS_HW_FB);
    ext_supply = 1'b1;
    cyc(2);
    rec(1);
    chk("mode", mode, OMS_NORM_HOST);
    ext_supply = 1'b0;
    ev(3);
    rst(9'h13E);
    chk("mode", mode, OMS_NORM_HOST);
    chk("st", status, 8'h00);
  endtask
  task t_alone();
    rst(9'h03E);
    chk("mode", mode, OMS_NORM_ALONE);
    chk("host", host_mode, 1'b0);
    ev(3);
    chk("mode", mode, OMS_NORM_ALONE);
    chk("dith", dither, 1'b1);
    pins.serial_data_input = 1'b0;
    cyc(4);
    chk("dith", dither, 1'b0);
    pins.regulator_overtemp = 1'b1;
    pins.host_detect_reset_pin = 1'b1;
    cyc(4);
    chk("mode", mode, OMS_NORM_ALONE);
    chk("supply", sup_en, 1'b0);
    chk("host", host_mode, 1'b0);
  endtask
  task t_sfail();
    rst(9'h134);
    chk("mode", mode, OMS_START_FAIL);
    chk("supply", sup_en, 1'b0);
    pins.dim_logic_input = 1'b1;
    cyc(4);
    chk("conv", conv, 1'b0);
    pins.battery_above_min = 1'b1;
    cyc(4);
    chk("conv", conv, 1'b1);
  endtask
  task t_stt();
    rst(9'h132);
    cyc(30);
    chk("mode", mode, OMS_START);
    cyc(15);
    chk("mode", mode, OMS_HW_FB);
    chk("stf", status.startup_timeout_flag, 1'b1);
    rst(9'h136);
    cyc(80);
    chk("mode", mode, OMS_START);
    cyc(30);
    chk("mode", mode, OMS_HW_FB);
    pins = 9'h13E;
    cyc(4);
    toggle_en();
    chk("mode", mode, OMS_NORM_HOST);
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // whole sequence needs under 2000 cycles; allow ten times that
  initial begin
    #200000;
    err_count++;
    final_report();
  end
  initial begin
    cyc(20);
    t_start();
    t_wd();
    t_uv();
    t_stuck();
    t_soft();
    t_ot();
    t_three();
    t_alone();
    t_sfail();
    t_stt();
    final_report();
  end
endmodule
`default_nettype wire
